// >>> src/bridge_hdr_pkg.sv
/*
  Package for the bridge header register bank: register indices, byte
  addresses, reset values, field positions and the structs that carry
  the bus numbers and the I/O window out of the bank.
  Assumes a 32-bit AXI4-Lite register bus with one register per word.
*/
package bridge_hdr_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] IDX_PLT  = 8'h0D;
  localparam logic [7:0] IDX_HDR  = 8'h0E;
  localparam logic [7:0] IDX_SELF_TEST_CONTROL = 8'h0F;
  localparam logic [7:0] IDX_BASE_ADDRESS_0 = 8'h10;
  localparam logic [7:0] IDX_BASE_ADDRESS_1 = 8'h14;
  localparam logic [7:0] IDX_UP   = 8'h18;
  localparam logic [7:0] IDX_DOWN = 8'h19;
  localparam logic [7:0] IDX_HIGH = 8'h1A;
  localparam logic [7:0] IDX_SLT  = 8'h1B;
  localparam logic [7:0] IDX_IOLO = 8'h1C;
  localparam logic [7:0] IDX_IOHI = 8'h1D;
  localparam logic [7:0] IDX_CTRL = 8'h20;

  localparam logic [7:0] ADR_PLT  = IDX_PLT << 2;
  localparam logic [7:0] ADR_HDR  = IDX_HDR << 2;
  localparam logic [7:0] ADR_SELF_TEST_CONTROL = IDX_SELF_TEST_CONTROL << 2;
  localparam logic [7:0] ADR_BASE_ADDRESS_0 = IDX_BASE_ADDRESS_0 << 2;
  localparam logic [7:0] ADR_BASE_ADDRESS_1 = IDX_BASE_ADDRESS_1 << 2;
  localparam logic [7:0] ADR_UP   = IDX_UP << 2;
  localparam logic [7:0] ADR_DOWN = IDX_DOWN << 2;
  localparam logic [7:0] ADR_HIGH = IDX_HIGH << 2;
  localparam logic [7:0] ADR_SLT  = IDX_SLT << 2;
  localparam logic [7:0] ADR_IOLO = IDX_IOLO << 2;
  localparam logic [7:0] ADR_IOHI = IDX_IOHI << 2;
  localparam logic [7:0] ADR_CTRL = IDX_CTRL << 2;

  // Fixed read values and reset values
  localparam logic [7:0]  PLT_VAL   = 8'h00;
  localparam logic [7:0]  HDR_VAL   = 8'h01;
  localparam logic [7:0]  SELF_TEST_CONTROL_VAL  = 8'h00;
  localparam logic [31:0] BAR_VAL   = 32'h0000_0000;
  localparam logic [7:0]  SLT_VAL   = 8'h00;
  localparam logic [7:0]  BUS_RST   = 8'h00;
  localparam logic        CAP_RST   = 1'b1;
  localparam logic [3:0]  BASE_RST  = 4'hF;
  localparam logic [3:0]  LIMIT_RST = 4'h0;

  // Field positions inside the I/O window bytes and the control word
  localparam int CAP_BIT   = 0;
  localparam int ADDR_LSB  = 4;
  localparam int ADDR_MSB  = 7;
  localparam int UNLK_BIT  = 0;
  localparam int FWD_BIT   = 8;
  localparam logic [11:0] PAGE_LOW  = 12'h000;
  localparam logic [11:0] PAGE_HIGH = 12'hFFF;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef struct packed {
    logic [7:0] upstream;
    logic [7:0] downstream;
    logic [7:0] highest;
  } bus_numbers_t;

  typedef struct packed {
    logic       width32;
    logic [3:0] base;
    logic [3:0] limit;
  } io_window_t;

endpackage

// >>> src/bridge_header_bus_io_regs.sv
/*
  Bridge header register bank from the primary latency timer through the
  I/O limit byte, reached over AXI4-Lite, plus the I/O forwarding check.
  Assumes one clock, synchronous active-low reset, and a master that keeps
  at most one write and one read outstanding.
*/
// Chosen here: register access over AXI4-Lite.
// Function
// - Primary latency timer reads zero, read-only
// - Header type byte reads one
// - Self-test byte reads zero, writes ignored
// - Both base address registers read zero
// - Upstream bus number stored, no effect
// - Downstream bus number read/write, reset zero
// - Highest bus behind read/write, reset zero
// - Secondary latency timer reads zero, read-only
// - Width capability bit resets one, lockable write
// - Window low address field, reset 0xF
// - Window high address field, low bits ones
// - High byte bit zero mirrors capability
// - Window decides which I/O requests forward
`timescale 1ns/1ps

module bridge_header_bus_io_regs
  import bridge_hdr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              io_req_valid,
  input  wire logic [31:0]       io_req_addr,
  input  wire logic [15:0]       io_upper_base,
  input  wire logic [15:0]       io_upper_limit,
  output logic                   io_fwd,
  output logic                   io_fwd_valid,
  output bus_numbers_t           bus_numbers,
  output io_window_t             io_window
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [7:0]        wbyte_reg;
  logic              wlane0_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  bus_numbers_t      bus_reg;
  io_window_t        win_reg;
  logic              unlock_reg;
  logic              fwd_reg;
  logic              fwd_valid_reg;
  logic              wr_fire;
  logic              wr_byte;
  logic              wr_mapped;
  logic              rd_mapped;
  logic [31:0]       rd_val;
  logic [31:0]       win_lo;
  logic [31:0]       win_hi;
  logic              in_win;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side
  // Address and data may arrive in either order; the write lands once both
  // are held, so a single held pair is all the buffering needed.
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready  = !w_have_reg && !bvalid_reg;
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_byte = wr_fire && wlane0_reg;  // Narrow registers live in lane 0
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;

  // Write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (awvalid && awready) begin
      aw_have_reg <= 1'b1;
      wr_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  // Write data holding; only the low byte matters to this bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      wbyte_reg  <= 8'h00;
      wlane0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_have_reg <= 1'b1;
      wbyte_reg  <= wdata[7:0];
      wlane0_reg <= wstrb[0];
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // Which byte addresses exist; read-only ones answer OKAY and drop data
  always_comb begin
    case (wr_addr_reg)
      ADR_PLT, ADR_HDR, ADR_SELF_TEST_CONTROL, ADR_BASE_ADDRESS_0, ADR_BASE_ADDRESS_1,
      ADR_UP, ADR_DOWN, ADR_HIGH, ADR_SLT,
      ADR_IOLO, ADR_IOHI, ADR_CTRL: wr_mapped = 1'b1;
      default:                      wr_mapped = 1'b0;
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus number registers: stored for software and driven out on bus_numbers, no decode use here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_reg <= '{BUS_RST, BUS_RST, BUS_RST};
    end else if (wr_byte) begin
      if (wr_addr_reg == ADR_UP)
        bus_reg.upstream <= wbyte_reg;
      if (wr_addr_reg == ADR_DOWN)
        bus_reg.downstream <= wbyte_reg;
      if (wr_addr_reg == ADR_HIGH)
        bus_reg.highest <= wbyte_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // I/O window registers
  // The width capability only moves while unlocked; leaving it locked at
  // reset keeps a stray write from flipping the decode width.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_reg.width32 <= CAP_RST;
      win_reg.base    <= BASE_RST;
      win_reg.limit   <= LIMIT_RST;
    end else if (wr_byte) begin
      if (wr_addr_reg == ADR_IOLO) begin
        win_reg.base <= wbyte_reg[ADDR_MSB:ADDR_LSB];
        if (unlock_reg)
          win_reg.width32 <= wbyte_reg[CAP_BIT];
      end
      if (wr_addr_reg == ADR_IOHI)
        win_reg.limit <= wbyte_reg[ADDR_MSB:ADDR_LSB];
    end
  end

  // Capability unlock control
  always_ff @(posedge aclk) begin
    if (!aresetn)
      unlock_reg <= 1'b0;
    else if (wr_byte && wr_addr_reg == ADR_CTRL)
      unlock_reg <= wbyte_reg[UNLK_BIT];
  end

  assign bus_numbers = bus_reg;
  assign io_window   = win_reg;

  ////////////////////////////////////////////////////////////////////////
  // I/O forwarding decision
  // The upper halves only count in 32-bit mode; in 16-bit mode any address
  // above 64K misses the window.
  assign win_lo = {win_reg.width32 ? io_upper_base : 16'h0000,
                   win_reg.base, PAGE_LOW};
  assign win_hi = {win_reg.width32 ? io_upper_limit : 16'h0000,
                   win_reg.limit, PAGE_HIGH};
  assign in_win = (io_req_addr >= win_lo) && (io_req_addr <= win_hi);

  // Base above limit leaves an empty window when the upper halves are equal (always in 16-bit mode), so nothing forwards
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_reg       <= 1'b0;
      fwd_valid_reg <= 1'b0;
    end else begin
      fwd_valid_reg <= io_req_valid;
      if (io_req_valid)
        fwd_reg <= in_win;
    end
  end

  assign io_fwd       = fwd_reg;
  assign io_fwd_valid = fwd_valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_mapped = 1'b1;
    rd_val    = '0;
    case (araddr)
      ADR_PLT:  rd_val = {24'h000000, PLT_VAL};
      ADR_HDR:  rd_val = {24'h000000, HDR_VAL};
      ADR_SELF_TEST_CONTROL: rd_val = {24'h000000, SELF_TEST_CONTROL_VAL};
      ADR_BASE_ADDRESS_0: rd_val = BAR_VAL;
      ADR_BASE_ADDRESS_1: rd_val = BAR_VAL;
      ADR_UP:   rd_val = {24'h000000, bus_reg.upstream};
      ADR_DOWN: rd_val = {24'h000000, bus_reg.downstream};
      ADR_HIGH: rd_val = {24'h000000, bus_reg.highest};
      ADR_SLT:  rd_val = {24'h000000, SLT_VAL};
      ADR_IOLO: rd_val = {24'h000000, win_reg.base, 3'b000, win_reg.width32};
      ADR_IOHI: rd_val = {24'h000000, win_reg.limit, 3'b000, win_reg.width32};
      ADR_CTRL: rd_val = {23'h000000, fwd_reg, 7'h00, unlock_reg};
      default:  rd_mapped = 1'b0;
    endcase
  end

  // Read channel: data is captured at the address handshake
  assign arready = !rvalid_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking ck @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_plt_zero;
    arvalid && arready && araddr == ADR_PLT |=> rdata == 32'h0000_0000;
  endproperty
  a_plt_zero: assert property (p_plt_zero) else $error("latency timer not zero");

  property p_hdr_one;
    arvalid && arready && araddr == ADR_HDR |=> rvalid && rdata == 32'h0000_0001;
  endproperty
  a_hdr_one: assert property (p_hdr_one) else $error("header type not one");

  property p_self_test_control_zero;
    arvalid && arready && araddr == ADR_SELF_TEST_CONTROL |=> rdata == 32'h0 && rresp == RESP_OKAY;
  endproperty
  a_self_test_control_zero: assert property (p_self_test_control_zero) else $error("self-test not zero");

  property p_bar_zero;
    arvalid && arready && (araddr == ADR_BASE_ADDRESS_0 || araddr == ADR_BASE_ADDRESS_1) |=> rdata == 32'h0;
  endproperty
  a_bar_zero: assert property (p_bar_zero) else $error("base address not zero");

  property p_up_store;
    wr_byte && wr_addr_reg == ADR_UP |=> bus_numbers.upstream == $past(wbyte_reg);
  endproperty
  a_up_store: assert property (p_up_store) else $error("upstream bus lost");

  property p_down_store;
    wr_byte && wr_addr_reg == ADR_DOWN |=> bvalid ##0 bus_numbers.downstream == $past(wbyte_reg);
  endproperty
  a_down_store: assert property (p_down_store) else $error("downstream bus lost");

  property p_high_hold;
    !(wr_byte && wr_addr_reg == ADR_HIGH) |=> $stable(bus_numbers.highest);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("highest bus moved");

  property p_slt_zero;
    arvalid && arready && araddr == ADR_SLT |=> rdata[7:0] == 8'h00;
  endproperty
  a_slt_zero: assert property (p_slt_zero) else $error("secondary timer not zero");

  property p_cap_lock;
    !unlock_reg |=> $stable(io_window.width32);
  endproperty
  a_cap_lock: assert property (p_cap_lock) else $error("locked capability moved");

  property p_base_reset;
    $rose(aresetn) |-> io_window.base == 4'hF && io_window.width32;
  endproperty
  a_base_reset: assert property (p_base_reset) else $error("window low reset wrong");

  property p_limit_store;
    wr_byte && wr_addr_reg == ADR_IOHI |=> io_window.limit == $past(wbyte_reg[7:4]);
  endproperty
  a_limit_store: assert property (p_limit_store) else $error("window high lost");

  property p_cap_mirror;
    arvalid && arready && araddr == ADR_IOHI |=> rdata[0] == $past(io_window.width32);
  endproperty
  a_cap_mirror: assert property (p_cap_mirror) else $error("capability not mirrored");

  property p_fwd;
    io_req_valid |=> io_fwd_valid && io_fwd == $past(in_win);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward decision wrong");

  property p_rsvd_zero;
    arvalid && arready && (araddr == ADR_IOLO || araddr == ADR_IOHI) |=> rdata[3:1] == 3'b000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  // Answer channels must free up after one accepted ready, or the master
  // would stall with its next request refused forever
  property p_b_clear;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("write answer not released");

  property p_r_clear;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_clear: assert property (p_r_clear) else $error("read answer not released");

  property p_rd_decerr;
    arvalid && arready && !rd_mapped |=> rresp == RESP_DECERR && rdata == 32'h0000_0000;
  endproperty
  a_rd_decerr: assert property (p_rd_decerr) else $error("hole read not refused");

  property p_base_store;
    wr_byte && wr_addr_reg == ADR_IOLO |=> io_window.base == $past(wbyte_reg[7:4]);
  endproperty
  a_base_store: assert property (p_base_store) else $error("window low lost");

  property p_iolo_rd;
    arvalid && arready && araddr == ADR_IOLO |=>
      rdata[0] == $past(io_window.width32) && rdata[7:4] == $past(io_window.base);
  endproperty
  a_iolo_rd: assert property (p_iolo_rd) else $error("window low read wrong");

  property p_bus_rst;
    $rose(aresetn) |-> bus_numbers == 24'h000000;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus numbers not reset");

  // A decision only moves when a request is taken
  property p_fwd_pulse;
    !io_req_valid |=> !io_fwd_valid && $stable(io_fwd);
  endproperty
  a_fwd_pulse: assert property (p_fwd_pulse) else $error("forward moved unasked");

  property p_win16_high;
    io_req_valid && !io_window.width32 && io_req_addr[31:16] != 16'h0000 |=> !io_fwd;
  endproperty
  a_win16_high: assert property (p_win16_high) else $error("16-bit window hit above 64K");

endmodule

// >>> tb/cfg_master_model.sv
/*
  Configuration master model: the software side of the register bus.
  Assumes the bench calls wr and rd one at a time, never in parallel.
*/
`timescale 1ns/1ps
module cfg_master_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address and data offered together, each dropped once taken; released
  // lines carry the inverse so a stale value can never pass for a good one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read: rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// >>> tb/test_bridge_header_bus_io_regs.sv
/*
  Self-checking bench for the bridge header register bank.
  Assumes the package, the design and the configuration master model.
*/
`timescale 1ns/1ps
module test_bridge_header_bus_io_regs
  import bridge_hdr_pkg::*;
;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, io_req_valid, io_fwd, io_fwd_valid;
  logic [7:0]   awaddr, araddr, v;
  logic [31:0]  wdata, rdata, io_req_addr, rd_data, e;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, resp;
  logic [15:0]  io_upper_base, io_upper_limit;
  bus_numbers_t bus_numbers;
  io_window_t   io_window;
  int           fails, check_count, cycles;
  // Register map: address, reset value, writable bits
  logic [7:0] adr_tab [11] = '{ADR_PLT, ADR_HDR, ADR_SELF_TEST_CONTROL, ADR_BASE_ADDRESS_0, ADR_BASE_ADDRESS_1, ADR_UP,
                               ADR_DOWN, ADR_HIGH, ADR_SLT, ADR_IOLO, ADR_IOHI};
  logic [7:0] rst_tab [11] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'hF1, 8'h01};
  logic [7:0] msk_tab [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
                               8'h00, 8'hF0, 8'hF0};
  // I/O probes: first five in 16-bit mode (window 0x4000..0x5FFF), rest in 32-bit mode
  logic [31:0] io_adr [10] = '{32'h0000_3FFF, 32'h0000_4000, 32'h0000_5FFF, 32'h0000_6000,
                               32'h0001_4000, 32'h0001_4000, 32'h0001_3FFF, 32'h0002_5FFF,
                               32'h0002_6000, 32'h0000_5000};
  logic        io_exp [10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  bridge_header_bus_io_regs i_bridge_header_bus_io_regs (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .io_req_valid(io_req_valid), .io_req_addr(io_req_addr), .io_upper_base(io_upper_base),
    .io_upper_limit(io_upper_limit), .io_fwd(io_fwd), .io_fwd_valid(io_fwd_valid),
    .bus_numbers(bus_numbers), .io_window(io_window));

  cfg_master_model i_cfg_master_model (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // Comparison and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    i_cfg_master_model.wr(a, d, s, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_cfg_master_model.rd(a, rd_data, resp);
    chk(rd_data, ed);
    chk({30'h0, resp}, {30'h0, er});
  endtask

  // Back-to-back I/O requests; each answer is checked while the next is taken
  task automatic io_run(input int first, input int last);
    for (int k = first; k <= last + 1; k++) begin
      @(posedge aclk);
      io_req_valid <= (k <= last);
      io_req_addr  <= (k <= last) ? io_adr[k] : ~io_adr[last];
      @(negedge aclk);
      if (k > first) begin
        chk({31'h0, io_fwd_valid}, 32'h1);
        chk({31'h0, io_fwd}, {31'h0, io_exp[k-1]});
      end
    end
    // The valid pulse lasts one cycle and the decision holds after it
    @(negedge aclk);
    chk({31'h0, io_fwd_valid}, 32'h0);
    chk({31'h0, io_fwd}, {31'h0, io_exp[last]});
  endtask

  task automatic test_done();
    $display("Checks: %0d  mismatches: %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole run needs well under a thousand cycles
  initial cycles = 0;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    aresetn = 1'b0;
    io_req_valid = 1'b0;
    io_req_addr = 32'h0000_0000;
    io_upper_base = 16'h0001;
    io_upper_limit = 16'h0002;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of the whole map except the control word
    for (int i = 0; i < 11; i++) begin
      e = {24'h0, rst_tab[i]};
      rd_chk(adr_tab[i], e, RESP_OKAY);
    end
    chk({8'h0, bus_numbers}, 32'h0);
    chk({23'h0, io_window}, 32'h0000_01F0);
    // Write every register but the control word with ones above a distinct low byte, then read back
    for (int i = 0; i < 11; i++) begin
      v = 8'hA0 + 8'(i);
      wr_chk(adr_tab[i], {24'hFFFFFF, v}, 4'hF, RESP_OKAY);
      e = {24'h0, (rst_tab[i] & ~msk_tab[i]) | (v & msk_tab[i])};
      rd_chk(adr_tab[i], e, RESP_OKAY);
    end
    chk({8'h0, bus_numbers}, 32'h00A5_A6A7);
    chk({23'h0, io_window}, 32'h0000_01AA);
    // Lane zero disabled: nothing stored
    wr_chk(ADR_UP, 32'h0000_0033, 4'hE, RESP_OKAY);
    rd_chk(ADR_UP, 32'h0000_00A5, RESP_OKAY);
    // Holes in the map answer with a decode error
    wr_chk(8'h44, 32'h0000_0001, 4'hF, RESP_DECERR);
    rd_chk(8'h44, 32'h0000_0000, RESP_DECERR);
    // Capability bit ignores writes while locked, takes them once unlocked
    wr_chk(ADR_IOLO, 32'h0000_0040, 4'hF, RESP_OKAY);
    rd_chk(ADR_IOLO, 32'h0000_0041, RESP_OKAY);
    wr_chk(ADR_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
    wr_chk(ADR_IOLO, 32'h0000_0040, 4'hF, RESP_OKAY);
    rd_chk(ADR_IOLO, 32'h0000_0040, RESP_OKAY);
    rd_chk(ADR_IOHI, 32'h0000_00A0, RESP_OKAY);
    wr_chk(ADR_IOHI, 32'h0000_0051, 4'hF, RESP_OKAY);
    rd_chk(ADR_IOHI, 32'h0000_0050, RESP_OKAY);
    // Forwarding in 16-bit mode ignores the upper halves, then 32-bit mode
    io_run(0, 4);
    wr_chk(ADR_IOLO, 32'h0000_0041, 4'hF, RESP_OKAY);
    rd_chk(ADR_IOHI, 32'h0000_0051, RESP_OKAY);
    io_run(5, 9);
    // Control word: unlock still set, last decision was a miss
    rd_chk(ADR_CTRL, 32'h0000_0001, RESP_OKAY);
    // Second reset in mid-run restores the defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ADR_UP, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADR_IOLO, 32'h0000_00F1, RESP_OKAY);
    rd_chk(ADR_CTRL, 32'h0000_0000, RESP_OKAY);
    test_done();
  end
endmodule
